//--- verilog/afm_consts.svh
// Constants for the conversion result formatter
`ifndef AFM_CONSTS_SVH
`define AFM_CONSTS_SVH
// Register byte offsets on the register bus
`define AFM_OFF_RESULT   8'h00
`define AFM_OFF_CONFIG   8'h04
`define AFM_OFF_STATUS   8'h08
`define AFM_OFF_COMMAND  8'h0C
// Config field positions
`define AFM_CFG_FMT_LO   0
`define AFM_CFG_FMT_HI   1
`define AFM_CFG_SCAN     2
`define AFM_CFG_HOLD     3
// Command bit: full reset of the result register
`define AFM_CMD_CLEAR    0
// Reset values
`define AFM_CFG_RESET    4'h0
`define AFM_CODE_RESET   17'h0_0000
// Filter sample layout: signed, value 1.0 x reference = 32768 << FRAC
`define AFM_SAMPLE_W     24
`define AFM_FRAC_W       6
// Clamp limits of the two codings
`define AFM_MAX17        17'h0_FFFF
`define AFM_MIN17        17'h1_0000
`define AFM_MAX16        16'h7FFF
`define AFM_MIN16        16'h8000
`define AFM_FIFO_DEPTH   32
`endif

//--- verilog/afm_pkg.sv
// Types shared by the conversion result formatter
package afm_pkg;
`include "afm_consts.svh"
   // Output layouts selected by the format field
   typedef enum logic [1:0] {
      AFM_FMT_16,
      AFM_FMT_32_LEFT,
      AFM_FMT_32_SIGNEXT,
      AFM_FMT_32_TAGGED
   } afm_format_t;
   // One completed conversion from the decimation filter
   typedef struct packed {
      logic [3:0]                     chan;
      logic signed [`AFM_SAMPLE_W-1:0] value;
   } afm_sample_t;
endpackage

//--- verilog/afm_formatter.sv
// Conversion result formatter with sample FIFO and Wishbone registers
// Functional notes
// - Result register at offset zero, 16-bit default
// - Round filter output to nearest LSb
// - Code equals Vin/Vref times 32768 times gain
// - Two-bit field selects one of four layouts
// - Format 0x: 16-bit signed, no overrange
// - 16-bit clamps at 0x7FFF and 0x8000
// - Format 00: only sixteen result bits
// - Format 01: left-justified, low bytes zero
// - Format 1x: 17-bit code, double range
// - 17-bit clamps at 0x0FFFF and 0x10000
// - 17-bit low bits match 16-bit coding
// - Format 10: right-justified, sign-filled upper bits
// - Format 11: channel tag in top nibble
// - Manual selection forces channel tag to zero
// - Update only on a completed conversion
// - Keep result across modes; clear on reset
`timescale 1ns/1ns
// Shared offsets and limits; guarded, so a second inclusion is harmless
`include "afm_consts.svh"

// Plain synchronous FIFO with valid/ready on both sides
module afm_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 32
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     in_valid_i,
   input  wire logic [WIDTH-1:0]         in_data_i,
   output logic                          in_ready_o,
   output logic                          out_valid_o,
   output logic [WIDTH-1:0]              out_data_o,
   input  wire logic                     out_ready_i,
   output logic [$clog2(DEPTH):0]        level_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];        // Storage words
   logic [AW-1:0]    wr_ptr;             // Next slot to fill
   logic [AW-1:0]    rd_ptr;             // Oldest word
   logic             push;               // Word accepted
   logic             pop;                // Word handed on
   logic [AW:0]      next_level;         // Occupancy after this edge

   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_valid_o = (level_o != '0);
   assign out_data_o  = mem[rd_ptr];

   // Occupancy follows pushes and pops
   always_comb begin
      next_level = level_o;
      if (push && !pop) begin
         next_level = level_o + 1'b1;
      end else if (pop && !push) begin
         next_level = level_o - 1'b1;
      end
   end

   // Level and registered ready; ready is held low while full
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o    <= '0;
         in_ready_o <= 1'b0;
      end else begin
         level_o    <= next_level;
         in_ready_o <= (next_level != (AW+1)'(DEPTH));
      end
   end

   // Pointers wrap naturally with a power-of-two depth
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // Data write needs no reset
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule

// Result formatter: rounding, clamping and layout of conversion results
module afm_formatter #(
   parameter int FIFO_DEPTH = `AFM_FIFO_DEPTH
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 smp_valid_i,
   input  wire afm_pkg::afm_sample_t smp_i,
   output logic                      smp_ready_o
);
   import afm_pkg::*;

   localparam int SW = $bits(afm_sample_t);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   logic [1:0]    fmt;              // Output layout select
   logic          scan;             // Automatic sequencing active
   logic          hold;             // Stall draining of the FIFO
   logic [16:0]   code;             // Stored 17-bit clamped code
   logic [3:0]    tag;              // Channel captured with the code
   logic          have_result;      // A conversion has been stored
   logic          f_valid;          // FIFO holds a sample
   logic [SW-1:0] f_data;           // Oldest sample, raw
   logic [LW-1:0] f_level;          // FIFO occupancy
   afm_sample_t   f_smp;            // Oldest sample, typed
   logic          pop;              // Sample taken into the result
   logic          req;              // New bus request this cycle
   logic          wr_take;          // Write takes effect at this edge
   logic          clr;              // Full reset command
   logic [31:0]   next_rdata;       // Read data to register

   // Round half up, then clamp into 17-bit two's complement
   function automatic logic [16:0] round_clamp(
      input logic signed [`AFM_SAMPLE_W-1:0] v
   );
      logic signed [`AFM_SAMPLE_W:0] sum;
      logic signed [`AFM_SAMPLE_W:0] q;
      sum = {v[`AFM_SAMPLE_W-1], v} + (`AFM_SAMPLE_W+1)'(32)
            ;
      q   = sum >>> `AFM_FRAC_W;
      if (q > $signed((`AFM_SAMPLE_W+1)'(65535))) begin
         round_clamp = `AFM_MAX17;
      end else if (q < -$signed((`AFM_SAMPLE_W+1)'(65536))) begin
         round_clamp = `AFM_MIN17;
      end else begin
         round_clamp = q[16:0];
      end
   endfunction

   // Narrow the 17-bit code to the locked 16-bit coding
   function automatic logic [15:0] to16(input logic [16:0] c);
      if (!c[16] && c[15]) begin
         to16 = `AFM_MAX16;
      end else if (c[16] && !c[15]) begin
         to16 = `AFM_MIN16;
      end else begin
         to16 = c[15:0];
      end
   endfunction

   // Lay the stored code out in the selected format
   function automatic logic [31:0] layout(
      input logic [1:0]  f,
      input logic [16:0] c,
      input logic [3:0]  t,
      input logic        s
   );
      logic [3:0] tg;
      tg = s ? t : 4'h0;
      case (afm_format_t'(f))
         AFM_FMT_16:         layout = {16'h0000, to16(c)};
         AFM_FMT_32_LEFT:    layout = {to16(c), 16'h0000};
         AFM_FMT_32_SIGNEXT: layout = {{15{c[16]}}, c};
         AFM_FMT_32_TAGGED:  layout = {tg, {11{c[16]}}, c};
         default:            layout = 32'h0000_0000;
      endcase
   endfunction

   // Sample buffer between the filter and the result register
   afm_fifo #(
      .WIDTH (SW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (smp_valid_i),
      .in_data_i   (smp_i),
      .in_ready_o  (smp_ready_o),
      .out_valid_o (f_valid),
      .out_data_o  (f_data),
      .out_ready_i (!hold),
      .level_o     (f_level)
   );

   assign f_smp   = afm_sample_t'(f_data);
   assign pop     = f_valid & !hold;
   // One request per ack; ack drops in the cycle after it was given
   assign req     = wb_cyc_i & wb_stb_i & !wb_ack_o;
   assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   assign clr     = wr_take && wb_adr_i == `AFM_OFF_COMMAND
                    && wb_sel_i[0] && wb_dat_i[`AFM_CMD_CLEAR];

   // Result register: only whole conversions land here
   always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
         code        <= `AFM_CODE_RESET;
         tag         <= 4'h0;
         have_result <= 1'b0;
      end else if (pop) begin
         code        <= round_clamp(f_smp.value);
         tag         <= f_smp.chan;
         have_result <= 1'b1;
      end
   end

   // Config register; mode changes leave the result alone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {hold, scan, fmt} <= `AFM_CFG_RESET;
      end else if (wr_take && wb_adr_i == `AFM_OFF_CONFIG
                   && wb_sel_i[0]) begin
         fmt  <= wb_dat_i[`AFM_CFG_FMT_HI:`AFM_CFG_FMT_LO];
         scan <= wb_dat_i[`AFM_CFG_SCAN];
         hold <= wb_dat_i[`AFM_CFG_HOLD];
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `AFM_OFF_RESULT:  next_rdata = layout(fmt, code, tag, scan);
         `AFM_OFF_CONFIG:  next_rdata = {28'h000_0000, hold, scan, fmt};
         `AFM_OFF_STATUS:  next_rdata = {22'h00_0000, have_result,
                                         smp_ready_o, 2'b00,
                                         6'(f_level)};
         default:          next_rdata = 32'h0000_0000;
      endcase
   end

   // Bus answer: ack one cycle after a request, data with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   // Checks on the stored code and on the word the bus hands back.
   // The expected rounding is a plain add-and-shift written apart
   // from the clamping function, so a slip in one shows in the other.
   logic [16:0] exp_code;           // Rounded code for in-range input
   logic        rd_res;             // Result read taken this cycle

   assign exp_code = 17'((f_smp.value + 24'sh00_0020) >>> `AFM_FRAC_W);
   assign rd_res   = req && !wb_we_i && wb_adr_i == `AFM_OFF_RESULT;

   // Code moves only on a take or a clear
   chk_hold_between: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !pop && !clr |=> $stable(code))
      else $error("result moved");

   // In-range samples round half up to the nearest code
   chk_round_near: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pop && !clr && f_smp.value < 24'sh3F_FF00
      && f_smp.value > -24'sh3F_FF00
      |=> code == $past(exp_code))
      else $error("rounding wrong");

   // Beyond twice full scale the code locks at the top
   chk_clamp_17: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pop && !clr && f_smp.value > 24'sh3F_FFFF
      |=> code == 17'h0_FFFF)
      else $error("17-bit clamp wrong");

   // Below twice negative full scale it locks at the bottom
   chk_clamp_17_low: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pop && !clr && f_smp.value < -24'sh40_0000
      |=> code == 17'h1_0000)
      else $error("17-bit low clamp wrong");

   // Positive overrange reads as the locked 16-bit top
   chk_clamp_16: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && !fmt[1] && !code[16] && code[15])
      |-> ($past(fmt[0]) ? wb_dat_o[31:16] : wb_dat_o[15:0])
      == 16'h7FFF)
      else $error("16-bit clamp wrong");

   // Negative overrange reads as the locked 16-bit bottom
   chk_clamp_16_low: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && !fmt[1] && code[16] && !code[15])
      |-> ($past(fmt[0]) ? wb_dat_o[31:16] : wb_dat_o[15:0])
      == 16'h8000)
      else $error("16-bit low clamp wrong");

   // Format 00 leaves the upper half empty
   chk_fmt_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && fmt == 2'b00)
      |-> wb_dat_o[31:16] == 16'h0000)
      else $error("format 00 upper half");

   // Format 01 pads the low half with zeros
   chk_fmt_left: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && fmt == 2'b01)
      |-> wb_dat_o[15:0] == 16'h0000)
      else $error("format 01 low half");

   // Format 10 repeats the sign through the upper bits
   chk_fmt_signext: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && fmt == 2'b10)
      |-> wb_dat_o[31:17] == {15{wb_dat_o[16]}})
      else $error("sign fill wrong");

   // Manual selection shows a zero tag
   chk_tag_manual: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && fmt == 2'b11 && !scan)
      |-> wb_dat_o[31:28] == 4'h0)
      else $error("manual tag not zero");

   // Sequencing shows the stored tag above the sign fill
   chk_tag_scan: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && fmt == 2'b11 && scan)
      |-> wb_dat_o[31:28] == $past(tag)
      && wb_dat_o[27:17] == {11{wb_dat_o[16]}})
      else $error("scan tag layout wrong");

   // The tag travels with the sample that carried it
   chk_tag_capture: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pop && !clr |=> tag == $past(f_smp.chan))
      else $error("tag not captured");

   // Within one reference the top bit only extends the sign
   chk_low_match: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && $past(rd_res && fmt[1] && code[16] == code[15])
      |-> wb_dat_o[16] == wb_dat_o[15])
      else $error("17-bit top not a sign copy");

   // A take marks the result present
   chk_have_result: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pop && !clr |=> have_result)
      else $error("result flag not set");

   // Full reset command empties the result
   chk_clear_cmd: assert property (
      @(posedge clk_i) disable iff (rst_i)
      clr |=> code == 17'h0_0000 && !have_result)
      else $error("clear failed");

   // A full buffer refuses samples rather than lose a whole one
   chk_ready_full: assert property (
      @(posedge clk_i) disable iff (rst_i)
      f_level == LW'(FIFO_DEPTH) |-> !smp_ready_o)
      else $error("ready while full");

   // Every request gets its answer at the next edge
   chk_ack_next: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req |=> wb_ack_o)
      else $error("ack late");

   // Ack is a one-cycle pulse, so a held strobe is not taken twice
   chk_ack_single: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
endmodule

//--- testbench/afm_filter_model.sv
// Behavioural decimation filter that offers samples over valid/ready
`timescale 1ns/1ns
module afm_filter_model (
   input  wire logic           clk_i,
   input  wire logic           smp_ready_i,
   output logic                smp_valid_o,
   output afm_pkg::afm_sample_t smp_o
);
   import afm_pkg::*;
   // Idle until the first sample is offered
   initial begin
      smp_valid_o = 1'b0;
      smp_o       = '0;
   end
   // Offer one sample, hold it until taken; bounded so a stall cannot hang
   task automatic send(input logic [3:0] chan, input int val, output bit ok);
      int n;
      ok = 1'b0;
      @(posedge clk_i);
      smp_valid_o <= 1'b1;
      smp_o       <= {chan, val[23:0]};
      for (n = 0; n < 200 && !ok; n++) begin
         @(posedge clk_i);
         ok = smp_ready_i;
      end
      smp_valid_o <= 1'b0;
      // Released payload is scrambled so stale data never looks valid
      smp_o       <= ~smp_o;
   endtask
endmodule

//--- testbench/afm_formatter_test.sv
// Self-checking bench for the conversion result formatter
`timescale 1ns/1ns
module afm_formatter_test;
   import afm_pkg::*;
   logic                 clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   logic                 wb_cyc_i = 1'b0;
   logic                 wb_stb_i = 1'b0;
   logic                 wb_we_i = 1'b0;
   logic [7:0]           wb_adr_i = 8'h00;
   logic [3:0]           wb_sel_i = 4'hF;
   logic [31:0]          wb_dat_i = 32'h0000_0000;
   logic [31:0]          wb_dat_o;
   logic                 wb_ack_o;
   logic                 smp_valid_i;
   afm_sample_t          smp_i;
   logic                 smp_ready_o;
   int                   n_mismatch = 0;
   int                   tests_run = 0;
   logic [31:0]          q;
   bit                   ok;
   int                   i;
   logic [3:0]           sel_use = 4'hF;  // Byte enables of next request

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   afm_formatter #(.FIFO_DEPTH(32)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid_i), .smp_i(smp_i),
      .smp_ready_o(smp_ready_o)
   );
   afm_filter_model u_flt (
      .clk_i(clk_i), .smp_ready_i(smp_ready_o),
      .smp_valid_o(smp_valid_i), .smp_o(smp_i)
   );

   // Report counts and verdict, then stop
   task automatic close_out();
      $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Compare one 32-bit word, four-state exact
   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   // Classic single Wishbone cycle, released only after ack is seen
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      r = 'x;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= sel_use;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) begin
            r = wb_dat_o;
            break;
         end
      end
      if (n == 50) begin
         n_mismatch++;
         close_out();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // At least one idle cycle between requests
      @(posedge clk_i);
   endtask

   // Expected register word from an integer code; clamps done here
   function automatic logic [31:0] exp_word(int c, logic [1:0] f,
                                            logic [3:0] t);
      int          a;
      int          b;
      logic [31:0] w;
      a = c > 65535 ? 65535 : (c < -65536 ? -65536 : c);
      b = c > 32767 ? 32767 : (c < -32768 ? -32768 : c);
      w = a;
      case (f)
         2'd0: exp_word = {16'h0000, b[15:0]};
         2'd1: exp_word = {b[15:0], 16'h0000};
         2'd2: exp_word = w;
         default: exp_word = {t, w[27:0]};
      endcase
   endfunction

   // Set layout, push one sample, read the result back
   task automatic scen(input int v, input int c, input logic [1:0] f,
                       input logic s, input logic [3:0] t);
      logic [31:0] r;
      bit          got;
      wb(1'b1, 8'h04, {28'h000_0000, 1'b0, s, f}, r);
      u_flt.send(t, v, got);
      check32({31'h0000_0000, got}, 32'h0000_0001);
      if (!got) close_out();
      // Result lands one edge after the take
      repeat (3) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0000_0000, r);
      check32(r, exp_word(c, f, s ? t : 4'h0));
   endtask

   // Hold draining, fill all 32 slots, then drain and see the last one
   task automatic fifo_fill();
      logic [31:0] r;
      bit          got;
      int          n;
      wb(1'b1, 8'h04, 32'h0000_0008, r);
      for (n = 0; n < 32; n++) begin
         u_flt.send(4'h1, n * 64, got);
         if (!got) begin
            n_mismatch++;
            close_out();
         end
      end
      wb(1'b0, 8'h08, 32'h0000_0000, r);
      check32(r & 32'h0000_013F, 32'h0000_0020);
      wb(1'b1, 8'h04, 32'h0000_0000, r);
      for (n = 0; n < 30 && r[5:0] !== 6'h00; n++) begin
         wb(1'b0, 8'h08, 32'h0000_0000, r);
      end
      // Drain that never empties counts as a failure
      if (r[5:0] !== 6'h00) begin
         n_mismatch++;
         close_out();
      end
      check32(r & 32'h0000_033F, 32'h0000_0300);
      repeat (3) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0000_0000, r);
      check32(r, 32'h0000_001F);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      check32(q, 32'h0000_0000);
      wb(1'b0, 8'h04, 32'h0000_0000, q);
      check32(q, 32'h0000_0000);
      // Config write without byte lane zero must be ignored
      sel_use = 4'hE;
      wb(1'b1, 8'h04, 32'h0000_0003, q);
      sel_use = 4'hF;
      wb(1'b0, 8'h04, 32'h0000_0000, q);
      check32(q, 32'h0000_0000);
      scen(1000 * 64 + 32, 1001, 2'd0, 1'b0, 4'h3);
      scen(1000 * 64 + 31, 1000, 2'd0, 1'b0, 4'h3);
      scen(-1000 * 64 - 33, -1001, 2'd0, 1'b0, 4'h3);
      for (i = 0; i < 4; i++) begin
         scen(40000 * 64, 40000, i[1:0], 1'b1, 4'hA);
         scen(-40000 * 64, -40000, i[1:0], 1'b1, 4'h6);
         scen(70000 * 64, 70000, i[1:0], 1'b1, 4'hC);
         scen(-70000 * 64, -70000, i[1:0], 1'b1, 4'h5);
         scen(-1000 * 64, -1000, i[1:0], 1'b0, 4'h9);
      end
      scen(32767 * 64, 32767, 2'd2, 1'b1, 4'h7);
      wb(1'b1, 8'h04, 32'h0000_0000, q);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      check32(q, 32'h0000_7FFF);
      wb(1'b1, 8'h00, 32'hFFFF_FFFF, q);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      check32(q, 32'h0000_7FFF);
      wb(1'b1, 8'h0C, 32'h0000_0001, q);
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      check32(q, 32'h0000_0000);
      wb(1'b0, 8'h10, 32'h0000_0000, q);
      check32(q, 32'h0000_0000);
      // Store a result, then pulse reset mid-run: it must be cleared
      scen(500 * 64, 500, 2'd1, 1'b0, 4'h2);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0000_0000, q);
      check32(q, 32'h0000_0000);
      fifo_fill();
      close_out();
   end
endmodule
